// ===== rtl/swd_port.sv
// Target end of a serial wire debug port with its register bus slave.
// Assumes the debug clock pin is far slower than clk and a pull-up on the data pin.
`timescale 1ns/1ps

// What this block does
// - Power-on or more than 50 high link cycles puts the port in reset.
// - From reset, at least two low link cycles move the port to idle.
// - Until an identification read succeeds, every packet is answered FAULT.
// - One undriven turnaround follows the request, then the port drives the ack.
// - Ack is three bits, bit 0 first: OK 1, WAIT 2, FAULT 4.
// - One undriven turnaround follows the ack before data or next request.
// - Data phase is 32 data bits plus one parity bit.
// - Data follows only OK, unless overrun detect is set.
// - Every field goes least significant bit first.
// - DP reads give OK and data, or WAIT, or FAULT and end.
// - AP reads are posted; the read buffer returns the last result.
// - Read-ok flag updates on every AP read and read buffer read that is answered OK.
// - Writes are buffered; full buffer answers WAIT except id, status, abort.
// - Pin select 0 routes pins to debug, 1 to general or boot use.
// - Security level 2 disables debug, leaving boot programming only.
// - Security level 3 disables debug and boot programming.
// - DP address decode: id/abort, control/wire, resend/select, read buffer.
// - Abort bit 0 abandons the current access.
module swd_port #(
  parameter logic [31:0] ID_CODE = 32'h1234_5677  // Arbitrary identification value
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register bus
  input  wire swd_pkg::avl_req_s avl_req,
  output logic [31:0]            avl_readdata,
  output logic                   avl_waitrequest,
  // Debug pins
  input  wire logic              debug_clock_pin,
  input  wire logic              debug_data_pin_in,
  output logic                   debug_data_pin_out,
  output logic                   debug_data_pin_oe_n,
  // Pin function
  input  wire logic [1:0]        security_level,
  output logic                   pins_gpio_en,
  output logic                   boot_programming_path_en,
  // Access port side
  output swd_pkg::ap_req_s       ap_req,
  input  wire swd_pkg::ap_rsp_s  ap_rsp,
  output logic                   ap_abort
);

  swd_pkg::st_s s_reg;
  swd_pkg::st_s s_next;
  logic         link_edge;
  logic         din;
  logic         dbg_en;
  logic         rq_ap;
  logic         rq_rd;
  logic [1:0]   rq_a;
  logic         idrd;
  logic         special;
  logic         orun_det;
  logic         bus_req;
  logic [2:0]   ack_pick;
  logic [31:0]  csw_rd;
  logic [31:0]  rd_val;

  // ==========================================================
  // Decode helpers
  assign link_edge = s_reg.clk_sy[1] & ~s_reg.clk_prev;
  assign din       = s_reg.dio_sy[1];
  assign dbg_en    = ~s_reg.pinsel && (security_level < swd_pkg::SEC_NO_DEBUG);
  assign rq_ap     = s_reg.req[swd_pkg::RQ_AP];
  assign rq_rd     = s_reg.req[swd_pkg::RQ_RD];
  assign rq_a      = s_reg.req[4:3];
  assign orun_det  = s_reg.csw[swd_pkg::CS_ORUN_DET];
  assign idrd      = ~rq_ap && rq_rd && (rq_a == swd_pkg::DP_ID_ABORT);
  assign special   = ~rq_ap && ((rq_a == swd_pkg::DP_ID_ABORT) ||
                     (rq_a == swd_pkg::DP_CTRL && rq_rd && ~s_reg.sel[swd_pkg::SEL_CTRLSEL]));
  assign bus_req   = avl_req.read | avl_req.write;

  always_comb begin
    csw_rd = s_reg.csw;
    csw_rd[swd_pkg::CS_STK_ORUN] = s_reg.stk_orun;
    csw_rd[swd_pkg::CS_STK_ERR]  = s_reg.stk_err;
    csw_rd[swd_pkg::CS_READ_OK]  = s_reg.read_ok;
  end

  // Ack choice at the end of the first turnaround
  always_comb begin
    if (!s_reg.active && !idrd) begin
      ack_pick = swd_pkg::ACK_FAULT;
    end else if (s_reg.stk_err && !special) begin
      ack_pick = swd_pkg::ACK_FAULT;
    end else if (s_reg.pend_v && !special) begin
      ack_pick = swd_pkg::ACK_WAIT;
    end else begin
      ack_pick = swd_pkg::ACK_OK;
    end
  end

  // Read value by address
  always_comb begin
    rd_val = s_reg.rdbuff;
    if (!rq_ap) begin
      case (rq_a)
        swd_pkg::DP_ID_ABORT:   rd_val = ID_CODE;
        swd_pkg::DP_CTRL:       rd_val = s_reg.sel[swd_pkg::SEL_CTRLSEL] ? s_reg.wcr : csw_rd;
        swd_pkg::DP_RESEND_SEL: rd_val = s_reg.resend;
        default:                rd_val = s_reg.rdbuff;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next          = s_reg;
    s_next.clk_sy   = {s_reg.clk_sy[0], debug_clock_pin};
    s_next.dio_sy   = {s_reg.dio_sy[0], debug_data_pin_in};
    s_next.clk_prev = s_reg.clk_sy[1];
    s_next.abort    = 1'b0;
    s_next.bus_ack  = bus_req & ~s_reg.bus_ack;

    // Buffered write or posted read drain
    if (s_reg.pend_v && !s_reg.pend.ap) begin
      if (s_reg.pend.a == swd_pkg::DP_CTRL) begin
        if (s_reg.sel[swd_pkg::SEL_CTRLSEL]) begin
          s_next.wcr = s_reg.pend.wd;
        end else begin
          s_next.csw = s_reg.pend.wd & swd_pkg::CS_WMASK;
        end
      end else if (s_reg.pend.a == swd_pkg::DP_RESEND_SEL) begin
        s_next.sel = s_reg.pend.wd & swd_pkg::SEL_WMASK;
      end
      s_next.pend_v = 1'b0;
    end else if (s_reg.pend_v && ap_rsp.done) begin
      s_next.pend_v = 1'b0;
      if (!s_reg.pend.wr) begin
        s_next.rdbuff  = ap_rsp.rdata;
        s_next.last_ok = ~ap_rsp.err;
      end
      if (ap_rsp.err) begin
        s_next.stk_err = 1'b1;
      end
    end

    // Link sequencing on each rising link clock edge
    if (link_edge) begin
      case (s_reg.state)
        swd_pkg::ST_LINE: begin
          s_next.oe_n = 1'b1;
        end
        swd_pkg::ST_RST: begin
          if (din) begin
            s_next.lo_cnt = 2'h0;
          end else if (s_reg.lo_cnt + 2'h1 >= swd_pkg::IDLE_LOW_MIN) begin
            s_next.state  = swd_pkg::ST_IDLE;
          end else begin
            s_next.lo_cnt = s_reg.lo_cnt + 2'h1;
          end
        end
        swd_pkg::ST_IDLE: begin
          if (din) begin
            s_next.req   = 8'h01;
            s_next.cnt   = 6'h01;
            s_next.state = swd_pkg::ST_REQ;
          end
        end
        swd_pkg::ST_REQ: begin
          s_next.req[s_reg.cnt[2:0]] = din;
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt == swd_pkg::REQ_LAST) begin
            if (^s_next.req[5:1] || s_next.req[swd_pkg::RQ_STOP]) begin
              s_next.state = swd_pkg::ST_LINE;
            end else begin
              s_next.state = swd_pkg::ST_TRN1;
            end
          end
        end
        swd_pkg::ST_TRN1: begin
          s_next.ack   = ack_pick;
          s_next.dout  = ack_pick[0];
          s_next.oe_n  = 1'b0;
          s_next.cnt   = 6'h00;
          s_next.state = swd_pkg::ST_ACK;
          s_next.sh    = 33'h0_0000_0000;
          if (ack_pick != swd_pkg::ACK_OK && orun_det) begin
            s_next.stk_orun = 1'b1;
          end
          if (ack_pick == swd_pkg::ACK_OK && rq_rd) begin
            s_next.sh     = {^rd_val, rd_val};
            s_next.resend = rd_val;
            if (idrd) begin
              s_next.active = 1'b1;
            end
            if (rq_ap || rq_a == swd_pkg::READ_BUFFER_REGISTER) begin
              s_next.read_ok = s_reg.last_ok;
            end
            if (rq_ap) begin
              s_next.pend_v = 1'b1;
              s_next.pend   = '{ap: 1'b1, wr: 1'b0, a: rq_a, wd: 32'h0000_0000};
            end
          end
        end
        swd_pkg::ST_ACK: begin
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt == swd_pkg::ACK_LAST) begin
            s_next.oe_n  = 1'b1;
            s_next.state = swd_pkg::ST_TRN2;
          end else begin
            s_next.dout = s_reg.ack[s_reg.cnt[1:0] + 2'h1];
          end
        end
        swd_pkg::ST_TRN2: begin
          s_next.cnt = 6'h00;
          if (s_reg.ack != swd_pkg::ACK_OK && !orun_det) begin
            s_next.state = swd_pkg::ST_IDLE;
          end else if (rq_rd) begin
            s_next.dout  = s_reg.sh[0];
            s_next.sh    = {1'b0, s_reg.sh[32:1]};
            s_next.oe_n  = 1'b0;
            s_next.state = swd_pkg::ST_RDATA;
          end else begin
            s_next.state = swd_pkg::ST_WDATA;
          end
        end
        swd_pkg::ST_RDATA: begin
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt == swd_pkg::DATA_LAST) begin
            s_next.oe_n  = 1'b1;
            s_next.state = swd_pkg::ST_TRN3;
          end else begin
            s_next.dout = s_reg.sh[0];
            s_next.sh   = {1'b0, s_reg.sh[32:1]};
          end
        end
        swd_pkg::ST_WDATA: begin
          s_next.sh  = {din, s_reg.sh[32:1]};
          s_next.cnt = s_reg.cnt + 6'h01;
          if (s_reg.cnt == swd_pkg::DATA_LAST) begin
            s_next.state = swd_pkg::ST_IDLE;
            if (s_reg.ack == swd_pkg::ACK_OK) begin
              if (^s_next.sh) begin
                s_next.stk_err = 1'b1;
              end else if (!rq_ap && rq_a == swd_pkg::DP_ID_ABORT) begin
                if (s_next.sh[swd_pkg::AB_ACCESS]) begin
                  s_next.pend_v = 1'b0;
                  s_next.abort  = 1'b1;
                end
                if (s_next.sh[swd_pkg::AB_STK_ERR]) begin
                  s_next.stk_err = s_reg.pend_v && s_reg.pend.ap && ap_rsp.done && ap_rsp.err;
                end
                if (s_next.sh[swd_pkg::AB_ORUN]) begin
                  s_next.stk_orun = 1'b0;
                end
              end else if (rq_ap || rq_a != swd_pkg::READ_BUFFER_REGISTER) begin
                s_next.pend_v = 1'b1;
                s_next.pend   = '{ap: rq_ap, wr: 1'b1, a: rq_a, wd: s_next.sh[31:0]};
              end
            end
          end
        end
        swd_pkg::ST_TRN3: begin
          s_next.state = swd_pkg::ST_IDLE;
        end
        default: begin
          s_next.state = swd_pkg::ST_LINE;
        end
      endcase

      // Line reset watch while the host owns the line
      if (s_reg.oe_n && din) begin
        if (s_reg.hi_cnt != swd_pkg::HI_CNT_MAX) begin
          s_next.hi_cnt = s_reg.hi_cnt + 6'h01;
        end
        if (s_next.hi_cnt > swd_pkg::LINE_RESET_HI) begin
          s_next.state  = swd_pkg::ST_RST;
          s_next.lo_cnt = 2'h0;
          s_next.active = 1'b0;
          s_next.oe_n   = 1'b1;
        end
      end else begin
        s_next.hi_cnt = 6'h00;
      end
    end

    // Pins taken away from the debug port
    if (!dbg_en) begin
      s_next.state  = swd_pkg::ST_LINE;
      s_next.oe_n   = 1'b1;
      s_next.active = 1'b0;
    end

    // Register bus slave, one wait state
    if (bus_req && !s_reg.bus_ack) begin
      case (avl_req.address)
        swd_pkg::OFS_SYSCTRL2: s_next.bus_rd = {31'h0000_0000, s_reg.pinsel};
        swd_pkg::OFS_STATUS:   s_next.bus_rd = {26'h000_0000, orun_det, s_reg.read_ok,
                                                s_reg.pend_v, s_reg.stk_err, dbg_en,
                                                s_reg.active};
        default:               s_next.bus_rd = 32'h0000_0000;
      endcase
    end
    if (avl_req.write && s_reg.bus_ack && avl_req.address == swd_pkg::OFS_SYSCTRL2 &&
        avl_req.byteenable[0]) begin
      s_next.pinsel = avl_req.writedata[swd_pkg::PINSEL_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.state  <= swd_pkg::ST_RST;
      s_reg.oe_n   <= 1'b1;
      s_reg.dout   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign avl_readdata             = s_reg.bus_rd;
  assign avl_waitrequest          = bus_req & ~s_reg.bus_ack;
  assign debug_data_pin_out       = s_reg.dout;
  assign debug_data_pin_oe_n      = s_reg.oe_n;
  assign pins_gpio_en             = s_reg.pinsel;
  assign boot_programming_path_en = s_reg.pinsel && (security_level != swd_pkg::SEC_NO_BOOT);
  assign ap_req   = '{valid: s_reg.pend_v & s_reg.pend.ap, wr: s_reg.pend.wr,
                      addr: {s_reg.sel[7:4], s_reg.pend.a, 2'h0}, wdata: s_reg.pend.wd};
  assign ap_abort = s_reg.abort;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_line_reset: assert property (
    (dbg_en && link_edge && din && s_reg.oe_n && s_reg.hi_cnt == swd_pkg::LINE_RESET_HI)
    |=> s_reg.state == swd_pkg::ST_RST) else $error("line reset missed");
  a_idle_entry: assert property (
    (dbg_en && link_edge && !din && s_reg.state == swd_pkg::ST_RST && s_reg.lo_cnt == 2'h1)
    |=> s_reg.state == swd_pkg::ST_IDLE) else $error("idle not entered");
  a_fault_inactive: assert property (
    (dbg_en && link_edge && s_reg.state == swd_pkg::ST_TRN1 && !s_reg.active && !idrd)
    |=> s_reg.ack == swd_pkg::ACK_FAULT) else $error("inactive port not faulting");
  a_turn_release: assert property (
    (s_reg.state == swd_pkg::ST_TRN1 || s_reg.state == swd_pkg::ST_TRN2 ||
     s_reg.state == swd_pkg::ST_TRN3) |-> s_reg.oe_n) else $error("driven in turnaround");
  a_ack_drive: assert property (
    (s_reg.state == swd_pkg::ST_ACK) |-> !s_reg.oe_n && s_reg.dout == s_reg.ack[s_reg.cnt[1:0]])
    else $error("ack bit wrong");
  a_data_gate: assert property (
    (s_reg.state == swd_pkg::ST_RDATA || s_reg.state == swd_pkg::ST_WDATA)
    |-> (s_reg.ack == swd_pkg::ACK_OK || orun_det)) else $error("data after bad ack");
  a_wait_full: assert property (
    (dbg_en && link_edge && s_reg.state == swd_pkg::ST_TRN1 && s_reg.active &&
     !s_reg.stk_err && s_reg.pend_v && !special)
    |=> s_reg.ack == swd_pkg::ACK_WAIT) else $error("full buffer not waiting");
  a_abort_drop: assert property (
    s_reg.abort |-> !s_reg.pend_v && !ap_req.valid) else $error("abort left access");
  a_debug_off: assert property (
    (security_level >= swd_pkg::SEC_NO_DEBUG) |=> s_reg.state == swd_pkg::ST_LINE && s_reg.oe_n)
    else $error("debug alive when locked");
  a_bus_answer: assert property (
    (bus_req && avl_waitrequest) |=> !avl_waitrequest) else $error("bus answer late");

endmodule : swd_port

// ===== rtl/swd_pkg.sv
// Shared constants and types of the serial wire debug port.
// Assumes one system clock; the debug pins arrive from outside it.
package swd_pkg;

  // ==========================================================
  // Register bus map
  localparam logic [3:0]  OFS_SYSCTRL2  = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam int          PINSEL_BIT    = 0;

  // ==========================================================
  // Link timing, in link clock cycles
  localparam logic [5:0]  LINE_RESET_HI = 6'h32;
  localparam logic [5:0]  HI_CNT_MAX    = 6'h3F;
  localparam logic [1:0]  IDLE_LOW_MIN  = 2'h2;
  localparam logic [5:0]  REQ_LAST      = 6'h07;
  localparam logic [5:0]  ACK_LAST      = 6'h02;
  localparam logic [5:0]  DATA_LAST     = 6'h20;

  // ==========================================================
  // Security levels and link codes
  localparam logic [1:0]  SEC_NO_DEBUG  = 2'h2;
  localparam logic [1:0]  SEC_NO_BOOT   = 2'h3;
  localparam logic [2:0]  ACK_OK        = 3'h1;
  localparam logic [2:0]  ACK_WAIT      = 3'h2;
  localparam logic [2:0]  ACK_FAULT     = 3'h4;
  localparam int          RQ_AP         = 1;
  localparam int          RQ_RD         = 2;
  localparam int          RQ_STOP       = 6;
  localparam logic [1:0]  DP_ID_ABORT   = 2'h0;
  localparam logic [1:0]  DP_CTRL       = 2'h1;
  localparam logic [1:0]  DP_RESEND_SEL = 2'h2;
  localparam logic [1:0]  READ_BUFFER_REGISTER     = 2'h3;

  // ==========================================================
  // Control/status, abort and select fields
  localparam int          CS_ORUN_DET   = 0;
  localparam int          CS_STK_ORUN   = 1;
  localparam int          CS_STK_ERR    = 5;
  localparam int          CS_READ_OK    = 6;
  localparam logic [31:0] CS_WMASK      = 32'hF000_0001;
  localparam int          AB_ACCESS     = 0;
  localparam int          AB_STK_ERR    = 2;
  localparam int          AB_ORUN       = 4;
  localparam int          SEL_CTRLSEL   = 0;
  localparam logic [31:0] SEL_WMASK     = 32'hFF00_00F1;

  typedef enum logic [9:0] {
    ST_LINE  = 10'h001,
    ST_RST   = 10'h002,
    ST_IDLE  = 10'h004,
    ST_REQ   = 10'h008,
    ST_TRN1  = 10'h010,
    ST_ACK   = 10'h020,
    ST_TRN2  = 10'h040,
    ST_RDATA = 10'h080,
    ST_WDATA = 10'h100,
    ST_TRN3  = 10'h200
  } link_state_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avl_req_s;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ap_req_s;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } ap_rsp_s;

  typedef struct packed {
    logic        ap;
    logic        wr;
    logic [1:0]  a;
    logic [31:0] wd;
  } pend_s;

  typedef struct packed {
    logic [1:0]  clk_sy;
    logic [1:0]  dio_sy;
    logic        clk_prev;
    link_state_e state;
    logic [5:0]  cnt;
    logic [5:0]  hi_cnt;
    logic [1:0]  lo_cnt;
    logic [7:0]  req;
    logic [2:0]  ack;
    logic [32:0] sh;
    logic        active;
    logic [31:0] csw;
    logic        stk_err;
    logic        stk_orun;
    logic        read_ok;
    logic        last_ok;
    logic [31:0] sel;
    logic [31:0] wcr;
    logic [31:0] resend;
    logic [31:0] rdbuff;
    logic        pend_v;
    pend_s       pend;
    logic        abort;
    logic        dout;
    logic        oe_n;
    logic        pinsel;
    logic        bus_ack;
    logic [31:0] bus_rd;
  } st_s;

endpackage : swd_pkg

// ===== tb/swd_host_model.sv
// Host probe model: makes the link clock and drives the shared data line.
// Assumes the bench clk; the link clock stands still between frames.
`timescale 1ns/1ps
module swd_host_model (
  // System clock
  input  wire logic clk,
  // Debug pins
  input  wire logic port_out,
  input  wire logic port_oe_n,
  output logic      link_clk,
  output logic      line
);
  logic host_oe;
  logic host_out;
  logic orun;  // Overrun detect mirrored: data phase after every ack

  // Pull-up wins when nobody drives
  assign line = !port_oe_n ? port_out : (host_oe ? host_out : 1'b1);

  initial begin
    link_clk = 1'b0;
    host_oe  = 1'b0;
    host_out = 1'b1;
    orun     = 1'b0;
  end

  // ==========================================================
  // One link period of 8 clk: set while low, sampled before rise
  task automatic cyc(input logic drv, input logic v, output logic s);
    @(posedge clk);
    link_clk <= 1'b0;
    host_oe  <= drv;
    host_out <= v;
    repeat (3) @(posedge clk);
    @(negedge clk);
    s = line;
    @(posedge clk);
    link_clk <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : cyc

  task automatic line_reset();
    logic s;
    for (int i = 0; i < 56; i++) cyc(1'b1, 1'b1, s);
    for (int i = 0; i < 4; i++) cyc(1'b1, 1'b0, s);
  endtask : line_reset

  // ==========================================================
  // Whole packet; bad flips the write data parity
  task automatic xfer(input logic ap, rd, input logic [1:0] a, input logic [31:0] wd,
                      input logic bad, output logic [2:0] ack, output logic [31:0] rdat,
                      output logic [1:0] trn, output logic pok);
    logic [7:0]  rq;
    logic [32:0] bits;
    logic        s;
    rq = {1'b1, 1'b0, ^{a, rd, ap}, a, rd, ap, 1'b1};
    bits = '1;
    for (int i = 0; i < 8; i++) cyc(i < 7, rq[i], s);
    cyc(1'b0, 1'b1, trn[0]);
    for (int i = 0; i < 3; i++) cyc(1'b0, 1'b1, ack[i]);
    cyc(1'b0, 1'b1, trn[1]);
    if ((ack == swd_pkg::ACK_OK || orun) && !rd) begin
      for (int i = 0; i < 33; i++) cyc(1'b1, i < 32 ? wd[i] : ^wd ^ bad, s);
      for (int i = 0; i < 2; i++) cyc(1'b1, 1'b0, s);
    end else if (ack == swd_pkg::ACK_OK || orun) begin
      for (int i = 0; i < 33; i++) cyc(1'b0, 1'b1, bits[i]);
      cyc(1'b0, 1'b1, s);
    end
    rdat = bits[31:0];
    pok = ~^bits;
    @(posedge clk);
    link_clk <= 1'b0;
    host_oe  <= 1'b0;
  endtask : xfer
endmodule : swd_host_model

// ===== tb/testbench.sv
// Self-checking bench of the serial wire debug port.
// Assumes the host model is compiled first; clk runs at 25 MHz.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID_VAL = 32'h5A3C_96E1;  // Arbitrary identification value
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  swd_pkg::avl_req_s avl = '0;
  logic [31:0]       avl_rdata;
  logic              avl_wait, link_clk, line, p_out, p_oe_n, gpio_en, boot_en, ap_abort;
  logic              ap_stall = 1'b0;
  logic [1:0]        sec = 2'h0;
  logic [1:0]        apw = 2'h0;
  swd_pkg::ap_req_s  ap_req;
  swd_pkg::ap_rsp_s  ap_rsp = '0;
  int                fails = 0;
  int                comparisons = 0;
  int                aborts = 0;

  always #20 clk = ~clk;

  swd_port #(.ID_CODE(ID_VAL)) dut (
    .clk(clk), .rst_n(rst_n), .avl_req(avl), .avl_readdata(avl_rdata),
    .avl_waitrequest(avl_wait), .debug_clock_pin(link_clk), .debug_data_pin_in(line),
    .debug_data_pin_out(p_out), .debug_data_pin_oe_n(p_oe_n), .security_level(sec),
    .pins_gpio_en(gpio_en), .boot_programming_path_en(boot_en), .ap_req(ap_req),
    .ap_rsp(ap_rsp), .ap_abort(ap_abort));
  swd_host_model host (.clk(clk), .port_out(p_out), .port_oe_n(p_oe_n),
    .link_clk(link_clk), .line(line));

  // ==========================================================
  // Access port responder, stalls on request
  always @(posedge clk) begin
    ap_rsp.done <= 1'b0;
    if (ap_abort) aborts <= aborts + 1;
    if (ap_req.valid && !ap_rsp.done && !ap_stall) begin
      apw <= apw + 2'h1;
      if (apw == 2'h3) begin
        ap_rsp.done  <= 1'b1;
        ap_rsp.rdata <= 32'hA55A_0000 | {24'h00_0000, ap_req.addr};
      end
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
    chk_val({29'h0, got}, {29'h0, exp});
  endtask : chk_ack

  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    avl <= '{read: !wr, write: wr, address: ad, byteenable: 4'hF, writedata: wd};
    // Held until waitrequest is sampled low; only the watchdog ends a hang
    @(posedge clk);
    while (avl_wait !== 1'b0) begin
      @(posedge clk);
    end
    rd = avl_rdata;
    avl <= '0;
  endtask : bus

  task automatic pkt(input logic ap, rd, input logic [1:0] a, input logic [31:0] wd,
                     input logic bad, input logic [2:0] exp, output logic [31:0] d);
    logic [2:0] ack;
    logic [1:0] trn;
    logic       pok;
    host.xfer(ap, rd, a, wd, bad, ack, d, trn, pok);
    chk_ack(ack, exp);
    chk_val({30'h0, trn}, 32'h0000_0003);
    if (rd && exp == swd_pkg::ACK_OK) chk_val({31'h0, pok}, 32'h0000_0001);
  endtask : pkt

  // ==========================================================
  // Scenarios
  task automatic t_basic();
    logic [31:0] d;
    bus(1'b0, swd_pkg::OFS_SYSCTRL2, '0, d);
    chk_val(d, 32'h0000_0000);
    host.line_reset();
    pkt(1'b0, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_FAULT, d);
    pkt(1'b0, 1'b1, 2'h0, '0, 1'b0, swd_pkg::ACK_OK, d);
    chk_val(d, ID_VAL);
    $display("t_basic done");
  endtask : t_basic

  task automatic t_posted();
    logic [31:0] d;
    pkt(1'b1, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b1, 1'b1, 2'h2, '0, 1'b0, swd_pkg::ACK_OK, d);
    chk_val(d, 32'hA55A_0004);
    pkt(1'b0, 1'b1, 2'h3, '0, 1'b0, swd_pkg::ACK_OK, d);
    chk_val(d, 32'hA55A_0008);
    bus(1'b0, swd_pkg::OFS_STATUS, '0, d);
    chk_val({31'h0, d[4]}, 32'h0000_0001);
    $display("t_posted done");
  endtask : t_posted

  task automatic t_errors();
    logic [31:0] d;
    pkt(1'b0, 1'b0, 2'h2, '0, 1'b1, swd_pkg::ACK_OK, d);
    pkt(1'b1, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_FAULT, d);
    pkt(1'b0, 1'b1, 2'h0, '0, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b0, 1'b0, 2'h0, 32'h0000_0004, 1'b0, swd_pkg::ACK_OK, d);
    ap_stall <= 1'b1;
    pkt(1'b1, 1'b0, 2'h1, 32'h1234_0000, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b1, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_WAIT, d);
    pkt(1'b0, 1'b1, 2'h0, '0, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b0, 1'b0, 2'h0, 32'h0000_0001, 1'b0, swd_pkg::ACK_OK, d);
    chk_val(32'(aborts), 32'h0000_0001);
    chk_val({31'h0, ap_req.valid}, 32'h0000_0000);
    ap_stall <= 1'b0;
    pkt(1'b1, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_OK, d);
    $display("t_errors done");
  endtask : t_errors

  task automatic t_overrun();
    logic [31:0] d;
    pkt(1'b0, 1'b0, 2'h1, 32'h0000_0001, 1'b0, swd_pkg::ACK_OK, d);
    host.orun = 1'b1;
    ap_stall <= 1'b1;
    pkt(1'b1, 1'b0, 2'h1, 32'h0000_0000, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b1, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_WAIT, d);
    chk_val(d, 32'h0000_0000);
    pkt(1'b0, 1'b1, 2'h1, '0, 1'b0, swd_pkg::ACK_OK, d);
    chk_val({30'h0, d[1:0]}, 32'h0000_0003);
    pkt(1'b0, 1'b0, 2'h0, 32'h0000_0011, 1'b0, swd_pkg::ACK_OK, d);
    pkt(1'b0, 1'b0, 2'h1, 32'h0000_0000, 1'b0, swd_pkg::ACK_OK, d);
    host.orun = 1'b0;
    ap_stall <= 1'b0;
    $display("t_overrun done");
  endtask : t_overrun

  task automatic t_pins();
    logic [31:0] d;
    bus(1'b1, swd_pkg::OFS_SYSCTRL2, 32'h0000_0001, d);
    @(posedge clk);
    chk_val({30'h0, gpio_en, boot_en}, 32'h0000_0003);
    pkt(1'b0, 1'b1, 2'h0, '0, 1'b0, 3'h7, d);
    @(posedge clk);
    sec <= 2'h3;
    repeat (2) @(posedge clk);
    chk_val({30'h0, gpio_en, boot_en}, 32'h0000_0002);
    sec <= 2'h2;
    bus(1'b1, swd_pkg::OFS_SYSCTRL2, 32'h0000_0000, d);
    @(posedge clk);
    chk_val({30'h0, gpio_en, boot_en}, 32'h0000_0000);
    host.line_reset();
    pkt(1'b0, 1'b1, 2'h0, '0, 1'b0, 3'h7, d);
    $display("t_pins done");
  endtask : t_pins

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_posted();
    t_errors();
    t_overrun();
    t_pins();
    stop_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : testbench
